// File: hw/insn_check_consts.svh
`ifndef INSN_CHECK_CONSTS_SVH
`define INSN_CHECK_CONSTS_SVH
// Primary opcodes
`define OP_CMPLI 6'h0a
`define OP_CMPI 6'h0b
`define OP_BRANCH_XL 6'h13
`define OP_EXT 6'h1f
// Extended opcodes under the extended primary opcode, except XO_RFI, which is under OP_BRANCH_XL
`define XO_CMP 10'h000
`define XO_CMPL 10'h020
`define XO_MFMSR 10'h053
`define XO_MTMSR 10'h092
`define XO_MTSR 10'h0d2
`define XO_MTSRIN 10'h0f2
`define XO_TLBIE 10'h132
`define XO_MFSPR 10'h153
`define XO_MTSPR 10'h1d3
`define XO_DCBI 10'h1d6
`define XO_MFSR 10'h253
`define XO_TLBSYNC 10'h236
`define XO_MFSRIN 10'h293
`define XO_DCBZ 10'h3f6
`define XO_RFI 10'h032
// Set of valid user D-form primary opcodes, one bit per opcode
`define USER_D_OPS 64'h000000110f00c188
// Field positions, little-endian index of big-endian bit n is 31-n
`define B_CMP_RSV 22
`define B_CMP_L 21
`define B_RC 0
`define B_MFSR_RSV 20
// State register layout
`define STATE_REG_WIDTH 32
`define STATE_REG_RESET 32'h0000_0000
`define STATE_REG_IMPL_MASK 32'h0000_ff73
`define WORD_TRAP_BIT_POS 7
`define RSV_READ_ZERO 1'b0
`define RSV_COPY 1'b1
`endif

// File: hw/insn_check_pkg.sv
package insn_check_pkg;
  typedef enum logic [3:0] {
    CL_ILLEGAL, CL_CMP_IMM, CL_CMP_REG, CL_MFSPR, CL_MTSPR, CL_MFMSR, CL_MTMSR,
    CL_MFSR, CL_MFSRIN, CL_MTSR, CL_MTSRIN, CL_DCBZ, CL_RFI, CL_SUPV, CL_USER
  } insn_class_t;
  typedef struct packed {
    logic done;
    logic execute;
    logic illegal_trap;
    logic priv_trap;
  } check_result_t;
endpackage

// File: hw/msr_reserved_filter.sv
`timescale 1ns/100ps
`include "insn_check_consts.svh"
module state_reg_filter #(
  parameter logic RSV_MODE = `RSV_READ_ZERO
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [`STATE_REG_WIDTH-1:0] wr_data,
  // Current value
  output logic [`STATE_REG_WIDTH-1:0] machine_state_register
);
  logic [`STATE_REG_WIDTH-1:0] state_next;

  always_comb begin
    if (RSV_MODE == `RSV_COPY) begin
      state_next = wr_data;
    end else begin
      // Bit 24 is outside the implemented mask, so it always reads zero
      state_next = wr_data & `STATE_REG_IMPL_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      machine_state_register <= `STATE_REG_RESET;
    end else if (wr_en) begin
      machine_state_register <= state_next;
    end
  end
endmodule

// File: hw/insn_privilege_form_check.sv
`timescale 1ns/100ps
`include "insn_check_consts.svh"
module insn_privilege_form_check #(
  parameter logic STATE_RSV_MODE = `RSV_READ_ZERO
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction under check
  input wire logic insn_valid,
  input wire logic [31:0] insn_word,
  input wire logic user_state,
  input wire logic [31:0] src_data,
  // Address operands
  input wire logic [31:0] addr_base,
  input wire logic [31:0] addr_disp,
  // Verdict
  output insn_check_pkg::check_result_t chk_result,
  output insn_check_pkg::insn_class_t insn_class,
  output logic [9:0] spr_num,
  output logic [31:0] effective_address,
  output logic [31:0] gpr_wr_data,
  output logic gpr_wr_en,
  output logic [31:0] machine_state_register
);
  import insn_check_pkg::*;

  insn_class_t class_next;
  logic rsv_bad;
  logic priv_need;
  logic illegal_next;
  logic priv_next;
  logic exec_next;
  logic state_wr_en;
  logic [9:0] spr_next;

  function automatic insn_class_t classify(input logic [31:0] w);
    logic [5:0] op;
    logic [9:0] xo;
    op = w[31:26];
    xo = w[10:1];
    classify = CL_ILLEGAL;
    if (op == `OP_CMPI || op == `OP_CMPLI) begin
      classify = CL_CMP_IMM;
    end else if (op == `OP_BRANCH_XL && xo == `XO_RFI) begin
      classify = CL_RFI;
    end else if (op == `OP_EXT) begin
      unique case (xo)
        `XO_CMP, `XO_CMPL: classify = CL_CMP_REG;
        `XO_MFSPR: classify = CL_MFSPR;
        `XO_MTSPR: classify = CL_MTSPR;
        `XO_MFMSR: classify = CL_MFMSR;
        `XO_MTMSR: classify = CL_MTMSR;
        `XO_MFSR: classify = CL_MFSR;
        `XO_MFSRIN: classify = CL_MFSRIN;
        `XO_MTSR: classify = CL_MTSR;
        `XO_MTSRIN: classify = CL_MTSRIN;
        `XO_DCBZ: classify = CL_DCBZ;
        `XO_DCBI, `XO_TLBIE, `XO_TLBSYNC: classify = CL_SUPV;
        default: classify = CL_ILLEGAL;
      endcase
    end else if (((`USER_D_OPS >> op) & 64'h1) != 64'h0) begin
      classify = CL_USER;
    end
  endfunction

  // Reserved fields per class; a set bit makes the form invalid
  always_comb begin
    rsv_bad = 1'b0;
    unique case (class_next)
      CL_CMP_IMM: rsv_bad = insn_word[`B_CMP_RSV];
      CL_CMP_REG: rsv_bad = insn_word[`B_CMP_RSV] | insn_word[`B_RC];
      CL_MFSPR, CL_MTSPR: rsv_bad = insn_word[`B_RC];
      CL_MFMSR, CL_MTMSR: rsv_bad = (|insn_word[20:11]) | insn_word[`B_RC];
      CL_MFSR, CL_MTSR: begin
        rsv_bad = insn_word[`B_MFSR_RSV] | (|insn_word[15:11]) | insn_word[`B_RC];
      end
      CL_MFSRIN, CL_MTSRIN: rsv_bad = (|insn_word[20:16]) | insn_word[`B_RC];
      CL_DCBZ: rsv_bad = (|insn_word[25:21]) | insn_word[`B_RC];
      CL_RFI: rsv_bad = |insn_word[25:11] | insn_word[`B_RC];
      default: rsv_bad = 1'b0;
    endcase
  end

  // Instruction bits 16 to 20 carry the lower number half; the upper half in bits 11 to 15 is dropped and forced to zero
  always_comb begin
    spr_next = {5'h00, insn_word[20:16]};
  end

  always_comb begin
    unique case (class_next)
      CL_MFMSR, CL_MFSR, CL_MFSRIN: priv_need = 1'b1;
      CL_MTMSR, CL_MTSR, CL_MTSRIN, CL_RFI, CL_SUPV: priv_need = 1'b1;
      // Top number bit marks supervisor registers; forced zero, so moves stay user-level
      CL_MFSPR, CL_MTSPR: priv_need = spr_next[9];
      CL_DCBZ: priv_need = 1'b0;
      default: priv_need = 1'b0;
    endcase
  end

  always_comb begin
    class_next = classify(insn_word);
  end

  always_comb begin
    illegal_next = (class_next == CL_ILLEGAL) | rsv_bad;
    priv_next = ~illegal_next & priv_need & user_state;
    exec_next = ~illegal_next & ~priv_next;
    state_wr_en = insn_valid & exec_next & (class_next == CL_MTMSR);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chk_result <= '0;
      insn_class <= CL_ILLEGAL;
      spr_num <= 10'h000;
    end else begin
      chk_result.done <= insn_valid;
      chk_result.execute <= insn_valid & exec_next;
      chk_result.illegal_trap <= insn_valid & illegal_next;
      chk_result.priv_trap <= insn_valid & priv_next;
      if (insn_valid) begin
        insn_class <= class_next;
        spr_num <= spr_next;
      end
    end
  end

  // Full sum; the state register plays no part here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      effective_address <= 32'h0000_0000;
    end else if (insn_valid) begin
      effective_address <= addr_base + addr_disp;
    end
  end

  // Write enable only for a committed state register read; data is loaded on every valid instruction
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpr_wr_en <= 1'b0;
      gpr_wr_data <= 32'h0000_0000;
    end else begin
      gpr_wr_en <= insn_valid & exec_next & (class_next == CL_MFMSR);
      if (insn_valid) begin
        gpr_wr_data <= machine_state_register;
      end
    end
  end

  state_reg_filter #(
    .RSV_MODE(STATE_RSV_MODE)
  ) u_state_reg (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(state_wr_en),
    .wr_data(src_data),
    .machine_state_register(machine_state_register)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_rsv_invalid;
    insn_valid && class_next != CL_ILLEGAL && rsv_bad |=> chk_result.illegal_trap;
  endproperty
  a_rsv_invalid: assert property (p_rsv_invalid) else $error("reserved bit not trapped");

  property p_cmp_bit10;
    insn_valid && insn_word[31:26] == `OP_CMPI && !insn_word[`B_CMP_RSV]
      |=> chk_result.execute || chk_result.priv_trap;
  endproperty
  a_cmp_bit10: assert property (p_cmp_bit10) else $error("compare bit 10 not ignored");

  property p_spr_high_zero;
    insn_valid |=> spr_num[9:5] == 5'h00 && spr_num[4:0] == $past(insn_word[20:16]);
  endproperty
  a_spr_high_zero: assert property (p_spr_high_zero) else $error("spr high bits kept");

  property p_priv_read;
    insn_valid && user_state && !rsv_bad
      && (class_next == CL_MFMSR || class_next == CL_MFSR)
      |=> chk_result.priv_trap && !chk_result.execute && !gpr_wr_en;
  endproperty
  a_priv_read: assert property (p_priv_read) else $error("privileged read ran");

  property p_dcbz_user;
    insn_valid && class_next == CL_DCBZ && !rsv_bad |=> !chk_result.priv_trap && chk_result.execute;
  endproperty
  a_dcbz_user: assert property (p_dcbz_user) else $error("cache zero trapped");

  property p_new_valid;
    insn_valid && class_next == CL_USER |=> chk_result.execute && !chk_result.illegal_trap;
  endproperty
  a_new_valid: assert property (p_new_valid) else $error("valid opcode refused");

  property p_trap_bit_reserved;
    ##1 !machine_state_register[`WORD_TRAP_BIT_POS] || STATE_RSV_MODE == `RSV_COPY;
  endproperty
  a_trap_bit_reserved: assert property (p_trap_bit_reserved) else $error("bit 24 held");

  property p_addr_full;
    insn_valid |=> effective_address == $past(addr_base) + $past(addr_disp);
  endproperty
  a_addr_full: assert property (p_addr_full) else $error("address bits masked");

  property p_rsv_zero;
    state_wr_en && STATE_RSV_MODE == `RSV_READ_ZERO
      |=> machine_state_register == ($past(src_data) & `STATE_REG_IMPL_MASK);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits stored");

  property p_unknown_trap;
    insn_valid && class_next == CL_ILLEGAL |=> chk_result.illegal_trap && !gpr_wr_en;
  endproperty
  a_unknown_trap: assert property (p_unknown_trap) else $error("unknown opcode ran");

  property p_no_commit;
    insn_valid && illegal_next |=> !chk_result.execute && $stable(machine_state_register);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("invalid form committed");

  c_priv_trap: cover property (chk_result.priv_trap);
  c_illegal: cover property (chk_result.illegal_trap);
  c_state_write: cover property (state_wr_en ##1 chk_result.execute);
  c_dcbz_user: cover property (insn_valid && user_state && class_next == CL_DCBZ);
endmodule

// File: sim/insn_privilege_form_check_tb_top.sv
`timescale 1ns/100ps
`include "insn_check_consts.svh"
module insn_privilege_form_check_tb_top;
  import insn_check_pkg::*;
  localparam logic [3:0] EXE = 4'b1100;
  localparam logic [3:0] ILL = 4'b1010;
  localparam logic [3:0] PRV = 4'b1001;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic [31:0] insn_word = 32'h0;
  logic user_state = 1'b0;
  logic [31:0] src_data = 32'h0;
  logic [31:0] addr_base = 32'h0;
  logic [31:0] addr_disp = 32'h0;
  check_result_t chk_result;
  insn_class_t insn_class;
  logic [9:0] spr_num;
  logic [31:0] effective_address;
  logic [31:0] gpr_wr_data;
  logic gpr_wr_en;
  logic [31:0] machine_state_register;
  int n_mismatch = 0;
  int num_checks = 0;
  int d_ops[11] = '{3, 7, 8, 14, 15, 24, 25, 26, 27, 32, 36};

  insn_privilege_form_check #(.STATE_RSV_MODE(`RSV_READ_ZERO)) i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .user_state(user_state),
    .src_data(src_data),
    .addr_base(addr_base),
    .addr_disp(addr_disp),
    .chk_result(chk_result),
    .insn_class(insn_class),
    .spr_num(spr_num),
    .effective_address(effective_address),
    .gpr_wr_data(gpr_wr_data),
    .gpr_wr_en(gpr_wr_en),
    .machine_state_register(machine_state_register)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Called at a falling edge; verdict is a one-cycle pulse, so look one cycle on
  task automatic issue(input logic [31:0] w, input logic u, input logic [3:0] er,
                       input insn_class_t ec, input logic ew);
    insn_word = w;
    user_state = u;
    insn_valid = 1'b1;
    @(negedge sys_clk);
    insn_valid = 1'b0;
    check("verdict", 32'(er), 32'(chk_result));
    check("class", 32'(ec), 32'(insn_class));
    if (ew !== 1'bx) begin
      check("gpr write", 32'(ew), 32'(gpr_wr_en));
    end
    // Idle cycle, so valid is never lowered and raised in one step
    @(negedge sys_clk);
    check("verdict end", 32'h0, 32'(chk_result));
  endtask

  function automatic logic [31:0] xf(input logic [9:0] xo, input logic [14:0] mid,
                                     input logic rc);
    return {`OP_EXT, mid, xo, rc};
  endfunction

  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    check("reset verdict", 32'h0, 32'(chk_result));
    check("reset class", 32'(CL_ILLEGAL), 32'(insn_class));
    check("reset state", 32'h0, machine_state_register);
    // The first four compare forms carry bit 10 set; it must not matter
    issue(xf(`XO_CMP, 15'h0443, 1'b0), 1'b1, EXE, CL_CMP_REG, 1'b0);
    issue(xf(`XO_CMPL, 15'h0443, 1'b0), 1'b1, EXE, CL_CMP_REG, 1'b0);
    issue({`OP_CMPI, 5'h1, 5'h3, 16'hfff0}, 1'b1, EXE, CL_CMP_IMM, 1'b0);
    issue({`OP_CMPLI, 5'h1d, 5'h3, 16'h0010}, 1'b1, EXE, CL_CMP_IMM, 1'b0);
    issue(xf(`XO_CMP, 15'h0843, 1'b0), 1'b1, ILL, CL_CMP_REG, 1'b0);
    issue(xf(`XO_CMPL, 15'h0043, 1'b1), 1'b1, ILL, CL_CMP_REG, 1'b0);
    issue(xf(`XO_DCBZ, {5'h1, 5'h3, 5'h4}, 1'b0), 1'b0, ILL, CL_DCBZ, 1'b0);
    issue({6'h01, 26'h0}, 1'b1, ILL, CL_ILLEGAL, 1'b0);
    // Special register moves with a nonzero upper number half
    issue(xf(`XO_MFSPR, {5'h2, 5'h1f, 5'h08}, 1'b0), 1'b1, EXE, CL_MFSPR, 1'bx);
    check("spr number", 32'h01f, 32'(spr_num));
    issue(xf(`XO_MTSPR, {5'h4, 5'h01, 5'h09}, 1'b0), 1'b1, EXE, CL_MTSPR, 1'bx);
    check("spr number", 32'h001, 32'(spr_num));
    issue(xf(`XO_MFMSR, 15'h1400, 1'b0), 1'b1, PRV, CL_MFMSR, 1'b0);
    issue(xf(`XO_MFSR, {5'h1, 1'b0, 4'h3, 5'h0}, 1'b0), 1'b1, PRV, CL_MFSR, 1'b0);
    issue(xf(`XO_MFSRIN, {5'h1, 5'h0, 5'h2}, 1'b0), 1'b1, PRV, CL_MFSRIN, 1'b0);
    issue(xf(`XO_DCBZ, {5'h0, 5'h3, 5'h4}, 1'b0), 1'b1, EXE, CL_DCBZ, 1'b0);
    issue({`OP_BRANCH_XL, 15'h0000, `XO_RFI, 1'b0}, 1'b1, PRV, CL_RFI, 1'b0);
    issue({`OP_BRANCH_XL, 15'h0001, `XO_RFI, 1'b0}, 1'b0, ILL, CL_RFI, 1'b0);
    issue(xf(`XO_TLBSYNC, 15'h0000, 1'b0), 1'b1, PRV, CL_SUPV, 1'b0);
    issue(xf(`XO_MTSR, {5'h2, 1'b0, 4'h3, 5'h0}, 1'b0), 1'b1, PRV, CL_MTSR, 1'b0);
    issue(xf(`XO_MTSRIN, {5'h2, 5'h0, 5'h4}, 1'b0), 1'b0, EXE, CL_MTSRIN, 1'b0);
    // Refused writes must leave the state register untouched
    src_data = 32'hffff_ffff;
    issue(xf(`XO_MTMSR, 15'h0800, 1'b0), 1'b1, PRV, CL_MTMSR, 1'b0);
    check("state", 32'h0, machine_state_register);
    issue(xf(`XO_MTMSR, 15'h0801, 1'b0), 1'b0, ILL, CL_MTMSR, 1'b0);
    check("state", 32'h0, machine_state_register);
    issue(xf(`XO_MTMSR, 15'h0800, 1'b0), 1'b0, EXE, CL_MTMSR, 1'b0);
    check("state", `STATE_REG_IMPL_MASK, machine_state_register);
    check("trap bit", 32'h0, 32'(machine_state_register[`WORD_TRAP_BIT_POS]));
    src_data = 32'h0;
    issue(xf(`XO_MFMSR, 15'h1400, 1'b0), 1'b0, EXE, CL_MFMSR, 1'b1);
    check("read data", `STATE_REG_IMPL_MASK, gpr_wr_data);
    // Odd low address bits must survive with every state bit set that can be
    foreach (d_ops[i]) begin
      addr_base = 32'h0000_1003 + 32'(d_ops[i]);
      addr_disp = 32'h0000_0002;
      issue({6'(d_ops[i]), 26'h0123456}, 1'b1, EXE, CL_USER, 1'b0);
      check("address", 32'h0000_1005 + 32'(d_ops[i]), effective_address);
    end
    // Reset again mid-run; every held output returns to idle
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    check("reset state", 32'h0, machine_state_register);
    check("reset address", 32'h0, effective_address);
    check("reset class", 32'(CL_ILLEGAL), 32'(insn_class));
    check("reset read data", 32'h0, gpr_wr_data);
    close_out();
  end
endmodule
